/* File: dv/sml_log_buffer_tb.sv */
// Self-checking testbench of the safety message log buffer
module sml_log_buffer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  sml_pkg::sml_msg_s msg_in;
  logic              cause_active;
  logic              irq;
  logic [32:0]       exp_q[$];
  logic [15:0]       mc[64];
  logic [15:0]       mn[64];
  logic [31:0]       mt[64];
  time               t0;
  logic [15:0]       chg;
  logic [15:0]       ncase;
  logic [2:0]        sts;
  logic [2:0]        msk;
  int                fill;
  int                err_count;
  int                tests_run;
  int                cyc;
  integer            seed;

  localparam int TB_CYC_MS = 10;

  sml_log_buffer #(.CYC_PER_MS(TB_CYC_MS)) dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .msg_in(msg_in), .cause_active(cause_active), .irq(irq));

  // ------------------------------------------------------------
  // Clock, timeout and result monitor
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic results();
    if (exp_q.size() != 0) err_count++;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end

  // Completed reads take the oldest note off the queue
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
      else err_count++;
    end
  end

  // ------------------------------------------------------------
  // Bus and message drivers with the reference model
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic send(input logic [1:0] k, input logic [15:0] c, input logic [15:0] n);
    int s;
    @(posedge clk_sys);
    msg_in <= '{valid: 1'b1, kind: k, code: c, number: n};
    @(posedge clk_sys);
    msg_in.valid <= 1'b0;
    if (k == sml_pkg::KIND_SAFETY) begin
      if (fill == 0) ncase++;
      s = (fill < 8) ? fill : 7;
      mc[s] = c;
      mn[s] = n;
      // Runtime in ms at the taking edge, counted from the last reset edge
      mt[s] = 32'((($time - t0) / sml_pkg::CLK_PERIOD_NS - 1) / TB_CYC_MS);
      if (fill < 8) fill++;
      chg++;
      sts[sml_pkg::STS_LOGGED] = 1'b1;
    end
  endtask

  task automatic ack();
    @(posedge clk_sys);
    cause_active <= 1'b0;
    @(posedge clk_sys);
    cause_active <= 1'b1;
    if (fill > 0) begin
      for (int i = 63; i >= 8; i--) begin
        mc[i] = mc[i-8];
        mn[i] = mn[i-8];
        mt[i] = mt[i-8];
      end
      for (int i = 0; i < 8; i++) begin
        mc[i] = 16'h0000;
        mn[i] = 16'h0000;
        mt[i] = 32'h0000_0000;
      end
      fill = 0;
      chg++;
      sts[sml_pkg::STS_ACKED] = 1'b1;
    end
  endtask

  // Full readout framed by two change counter reads
  task automatic check_all();
    rd(sml_pkg::ADDR_CHG, 32'(chg));
    rd(sml_pkg::ADDR_CASE, 32'(ncase));
    rd(sml_pkg::ADDR_STS, 32'(sts));
    rd(sml_pkg::ADDR_MSK, 32'(msk));
    rd(sml_pkg::ADDR_FILL, {27'h000_0000, fill != 0, 4'(fill)});
    for (int i = 0; i < 64; i++) begin
      rd(12'h100 + 12'(4 * i), 32'(mc[i]));
      rd(12'h200 + 12'(4 * i), 32'(mn[i]));
      rd(12'h300 + 12'(4 * i), mt[i]);
    end
    rd(sml_pkg::ADDR_CHG, 32'(chg));
    @(negedge clk_sys);
    chk(33'(irq), 33'(|(sts & msk)));
  endtask

  task automatic clear_model();
    for (int i = 0; i < 64; i++) begin
      mc[i] = 16'h0000;
      mn[i] = 16'h0000;
      mt[i] = 32'h0000_0000;
    end
    fill  = 0;
    ncase = 16'h0000;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed         = 32'h47ca;
    rst          = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    msg_in       = '0;
    cause_active = 1'b0;
    chg          = 16'h0000;
    sts          = 3'h0;
    msk          = 3'h0;
    clear_model();
    repeat (2) @(posedge clk_sys);
    t0           = $time;
    rst          <= 1'b0;
    cause_active <= 1'b1;
    check_all();
    rd(12'h014, 32'h0000_0000, 1'b1);
    wr_ignored: begin
      apb(1'b1, sml_pkg::ADDR_CHG, 32'h0000_ffff);
      apb(1'b1, 12'h400, 32'h0000_ffff);
    end
    for (int k = 0; k < 4; k++) begin
      if (k != 2) send(2'(k), 16'($random(seed)), 16'($random(seed)));
    end
    apb(1'b1, sml_pkg::ADDR_MSK, 32'h0000_0002);
    msk = 3'h2;
    for (int c = 0; c < 9; c++) begin
      for (int m = 0; m < ((c == 0) ? 9 : c); m++) begin
        send(sml_pkg::KIND_SAFETY, 16'($random(seed)), 16'($random(seed)));
      end
      check_all();
      if (c == 1) begin
        apb(1'b1, sml_pkg::ADDR_MSK, 32'h0000_0007);
        msk = 3'h7;
      end
      ack();
      check_all();
    end
    apb(1'b1, sml_pkg::ADDR_STS, 32'h0000_0007);
    sts = 3'h0;
    apb(1'b1, sml_pkg::ADDR_CASE, 32'h0000_0005);
    check_all();
    apb(1'b1, sml_pkg::ADDR_CASE, 32'h0000_0000);
    clear_model();
    chg++;
    sts[sml_pkg::STS_CLEARED] = 1'b1;
    check_all();
    results();
  end
endmodule

/* File: rtl/sml_log_buffer.sv */
// Safety message log buffer with APB register access
//
// Operation
// - Change counter counts every buffer content change
// - Only safety kind messages are logged
// - Current case in slots 0..7, oldest first
// - Case acknowledged automatically when cause gone
// - History case n starts at slot 8n
// - At most seven history cases kept; slot 63 last
// - Readable array of 64 message codes
// - Case counter; writing zero clears buffer
// - Each slot records runtime in milliseconds
module sml_log_buffer #(
  parameter int unsigned CYC_PER_MS = sml_pkg::CYC_PER_MS
) (
  input  wire logic              clk_sys,      // System clock
  input  wire logic              rst,          // Synchronous reset
  input  wire logic              psel,         // APB select
  input  wire logic              penable,      // APB enable
  input  wire logic              pwrite,       // APB direction
  input  wire logic       [11:0] paddr,        // APB byte address
  input  wire logic       [31:0] pwdata,       // APB write data
  output logic                   pready,       // APB ready
  output logic            [31:0] prdata,       // APB read data
  output logic                   pslverr,      // APB error
  input  wire sml_pkg::sml_msg_s msg_in,       // Incoming message
  input  wire logic              cause_active, // Current case cause present
  output logic                   irq           // Interrupt, active high
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    sml_pkg::sml_slot_s [sml_pkg::SLOT_NUM-1:0] slots;
    logic [sml_pkg::FILL_W-1:0]                 fill;
    logic                                       case_open;
    logic [15:0]                                chg_cnt;
    logic [15:0]                                case_cnt;
    logic [sml_pkg::STS_W-1:0]                  sts;
    logic [sml_pkg::STS_W-1:0]                  msk;
    logic [31:0]                                rdata;
    logic                                       slverr;
  } sml_state_s;

  sml_state_s         s_q;
  sml_state_s         s_d;
  logic        [31:0] time_ms;
  logic               setup;
  logic               wr_acc;
  logic               acc_evt;
  logic               ack_evt;
  logic               clr_evt;
  logic               chg_evt;
  logic         [2:0] wr_idx;
  sml_pkg::sml_slot_s entry;
  logic         [2:0] sts_evt;

  // ------------------------------------------------------------
  // Runtime source
  // ------------------------------------------------------------
  sml_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .time_ms (time_ms)
  );

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign acc_evt = msg_in.valid && (msg_in.kind == sml_pkg::KIND_SAFETY);
  assign ack_evt = s_q.case_open && !cause_active;
  assign clr_evt = wr_acc && (paddr == sml_pkg::ADDR_CASE)
                   && (pwdata[15:0] == 16'h0000);
  assign chg_evt = clr_evt | ack_evt | acc_evt;

  assign entry.time_ms = time_ms;
  assign entry.number  = msg_in.number;
  assign entry.code    = msg_in.code;

  assign sts_evt[sml_pkg::STS_LOGGED]  = acc_evt & ~clr_evt;
  assign sts_evt[sml_pkg::STS_ACKED]   = ack_evt & ~clr_evt;
  assign sts_evt[sml_pkg::STS_CLEARED] = clr_evt;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    wr_idx = 3'h0;

    if (clr_evt) begin
      s_d.slots     = '0;
      s_d.fill      = '0;
      s_d.case_open = 1'b0;
      s_d.case_cnt  = sml_pkg::CASE_RST;
    end else begin
      if (ack_evt) begin
        // Move current case into history; the seventh case falls off
        for (int i = sml_pkg::SLOT_NUM - 1; i >= sml_pkg::CASE_SLOTS; i--) begin
          s_d.slots[i] = s_q.slots[i - sml_pkg::CASE_SLOTS];
        end
        for (int j = 0; j < sml_pkg::CASE_SLOTS; j++) begin
          s_d.slots[j] = '0;
        end
        s_d.fill      = '0;
        s_d.case_open = 1'b0;
      end
      if (acc_evt) begin
        // A full current case keeps the latest message in slot 7
        if (s_d.fill < 4'(sml_pkg::CASE_SLOTS)) begin
          wr_idx   = s_d.fill[2:0];
          s_d.fill = s_d.fill + 4'h1;
        end else begin
          wr_idx = 3'h7;
        end
        s_d.slots[wr_idx] = entry;
        if (!s_d.case_open) begin
          s_d.case_open = 1'b1;
          s_d.case_cnt  = s_d.case_cnt + 16'h0001;
        end
      end
    end

    if (chg_evt) begin
      s_d.chg_cnt = s_q.chg_cnt + 16'h0001;
    end

    // Set wins over a write-one clear in the same cycle
    if (wr_acc && (paddr == sml_pkg::ADDR_STS)) begin
      s_d.sts = (s_q.sts & ~pwdata[sml_pkg::STS_W-1:0]) | sts_evt;
    end else begin
      s_d.sts = s_q.sts | sts_evt;
    end
    if (wr_acc && (paddr == sml_pkg::ADDR_MSK)) begin
      s_d.msk = pwdata[sml_pkg::STS_W-1:0];
    end

    // Read data and error are latched in the setup cycle
    if (setup) begin
      s_d.rdata  = 32'h0000_0000;
      s_d.slverr = 1'b0;
      case (paddr[11:8])
        sml_pkg::PAGE_REG: begin
          case (paddr)
            sml_pkg::ADDR_CHG:  s_d.rdata = {16'h0000, s_q.chg_cnt};
            sml_pkg::ADDR_CASE: s_d.rdata = {16'h0000, s_q.case_cnt};
            sml_pkg::ADDR_STS:  s_d.rdata = {29'h0000_0000, s_q.sts};
            sml_pkg::ADDR_MSK:  s_d.rdata = {29'h0000_0000, s_q.msk};
            sml_pkg::ADDR_FILL: s_d.rdata = {27'h000_0000, s_q.case_open, s_q.fill};
            default:            s_d.slverr = 1'b1;
          endcase
        end
        sml_pkg::PAGE_CODE: s_d.rdata = {16'h0000, s_q.slots[paddr[7:2]].code};
        sml_pkg::PAGE_NUM:  s_d.rdata = {16'h0000, s_q.slots[paddr[7:2]].number};
        sml_pkg::PAGE_TIME: s_d.rdata = s_q.slots[paddr[7:2]].time_ms;
        default:            s_d.slverr = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q          <= '0;
      s_q.chg_cnt  <= sml_pkg::CHG_RST;
      s_q.case_cnt <= sml_pkg::CASE_RST;
      s_q.sts      <= sml_pkg::STS_RST;
      s_q.msk      <= sml_pkg::MSK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pready  = psel & penable;
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign irq     = |(s_q.sts & s_q.msk);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic               [15:0] rd_code_peek;
  logic               [31:0] rd_time_peek;
  sml_pkg::sml_slot_s        tail_slot;
  logic                      plain_log;
  logic                      plain_ack;

  assign rd_code_peek = s_q.slots[paddr[7:2]].code;
  assign rd_time_peek = s_q.slots[paddr[7:2]].time_ms;
  assign tail_slot    = s_q.slots[3'(s_q.fill - 4'h1)];
  assign plain_log    = acc_evt && !ack_evt && !clr_evt && (s_q.fill < 4'h8);
  assign plain_ack    = ack_evt && !clr_evt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seq_code_setup;
    psel && !penable && !pwrite && (paddr[11:8] == sml_pkg::PAGE_CODE);
  endsequence

  sequence seq_time_setup;
    psel && !penable && !pwrite && (paddr[11:8] == sml_pkg::PAGE_TIME);
  endsequence

  sequence seq_clear_write;
    psel && penable && pwrite && (paddr == sml_pkg::ADDR_CASE)
      && (pwdata[15:0] == 16'h0000);
  endsequence

  property prop_code_read;
    seq_code_setup ##1 (psel && penable) |-> prdata == {16'h0000, $past(rd_code_peek)};
  endproperty

  chk_chg_count_step: assert property (
    chg_evt |=> s_q.chg_cnt == $past(s_q.chg_cnt) + 16'h0001)
    else $error("change counter did not step on a buffer change");

  chk_chg_count_hold: assert property (
    !chg_evt |=> $stable(s_q.chg_cnt))
    else $error("change counter moved without a buffer change");

  chk_kind_filter: assert property (
    (msg_in.valid && (msg_in.kind != sml_pkg::KIND_SAFETY) && !ack_evt && !clr_evt)
      |=> $stable(s_q.chg_cnt) && $stable(s_q.fill))
    else $error("non-safety message changed the log");

  chk_slot_order: assert property (
    plain_log |=> (s_q.fill == $past(s_q.fill) + 4'h1)
      && (tail_slot.code == $past(msg_in.code))
      && (tail_slot.number == $past(msg_in.number)))
    else $error("message not placed after the previous one");

  chk_auto_ack: assert property (
    (plain_ack && !acc_evt) |=> !s_q.case_open && (s_q.fill == 4'h0))
    else $error("gone cause did not close the current case");

  chk_hist_base: assert property (
    plain_ack |=> s_q.slots[8] == $past(s_q.slots[0]) && s_q.slots[15] == $past(s_q.slots[7]))
    else $error("current case not moved to slot 8");

  chk_hist_last: assert property (
    plain_ack |=> s_q.slots[63] == $past(s_q.slots[55]))
    else $error("slot 63 not taken from the sixth case");

  chk_code_read: assert property (prop_code_read)
    else $error("code array read returned wrong slot");

  chk_clear_all: assert property (
    seq_clear_write |=> (s_q.case_cnt == 16'h0000) && (s_q.fill == 4'h0)
      && (s_q.slots == '0) && !s_q.case_open)
    else $error("writing zero to case counter did not clear");

  chk_case_count: assert property (
    (acc_evt && !clr_evt && !s_q.case_open) |=> s_q.case_cnt == $past(s_q.case_cnt) + 16'h0001)
    else $error("case counter did not count a new case");

  chk_time_stamp: assert property (
    plain_log |=> tail_slot.time_ms == $past(time_ms))
    else $error("slot time does not match runtime at logging");

  chk_time_read: assert property (
    seq_time_setup ##1 (psel && penable) |-> prdata == $past(rd_time_peek))
    else $error("time array read returned wrong slot");

  chk_hist_shift: assert property (
    plain_ack |=> s_q.slots[16] == $past(s_q.slots[8]) && s_q.slots[56] == $past(s_q.slots[48]))
    else $error("history not shifted by one case");

  chk_irq_level: assert property (
    (s_q.sts[sml_pkg::STS_LOGGED] && s_q.msk[sml_pkg::STS_LOGGED]) |-> irq)
    else $error("unmasked status did not raise irq");

endmodule

/* File: rtl/sml_ms_timer.sv */
// Free running runtime counter in milliseconds
module sml_ms_timer #(
  parameter int unsigned CYC_PER_MS = sml_pkg::CYC_PER_MS
) (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        rst,      // Synchronous reset
  output logic      [31:0] time_ms   // Runtime since reset
);

  sml_pkg::sml_tmr_s s_q;
  sml_pkg::sml_tmr_s s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cyc == 32'(CYC_PER_MS - 1)) begin
      s_d.cyc = 32'h0000_0000;
      s_d.ms  = s_q.ms + 32'h0000_0001;
    end else begin
      s_d.cyc = s_q.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign time_ms = s_q.ms;

endmodule

/* File: rtl/sml_pkg.sv */
// Constants and types shared by the safety message log buffer
package sml_pkg;

  // ------------------------------------------------------------
  // Buffer geometry
  // ------------------------------------------------------------
  localparam int SLOT_NUM   = 64;
  localparam int CASE_SLOTS = 8;
  localparam int HIST_CASES = 7;
  localparam int FILL_W     = 4;

  // Message kind accepted by the log (encoding of the kind input)
  localparam logic [1:0] KIND_SAFETY = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1_000_000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CHG  = 12'h000;
  localparam logic [11:0] ADDR_CASE = 12'h004;
  localparam logic [11:0] ADDR_STS  = 12'h008;
  localparam logic [11:0] ADDR_MSK  = 12'h00C;
  localparam logic [11:0] ADDR_FILL = 12'h010;
  localparam logic [3:0]  PAGE_REG  = 4'h0;
  localparam logic [3:0]  PAGE_CODE = 4'h1;
  localparam logic [3:0]  PAGE_NUM  = 4'h2;
  localparam logic [3:0]  PAGE_TIME = 4'h3;

  // Interrupt status bit positions
  localparam int STS_W       = 3;
  localparam int STS_LOGGED  = 0;
  localparam int STS_ACKED   = 1;
  localparam int STS_CLEARED = 2;

  // Values after reset
  localparam logic [15:0]      CHG_RST  = 16'h0000;
  localparam logic [15:0]      CASE_RST = 16'h0000;
  localparam logic [STS_W-1:0] STS_RST  = 3'h0;
  localparam logic [STS_W-1:0] MSK_RST  = 3'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] time_ms;
    logic [15:0] number;
    logic [15:0] code;
  } sml_slot_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [15:0] code;
    logic [15:0] number;
  } sml_msg_s;

  typedef struct packed {
    logic [31:0] cyc;
    logic [31:0] ms;
  } sml_tmr_s;

endpackage
